// ### hw/acd_core.sv
// Serial register port and conversion control of the data-acquisition block.
// Assumes a host driving sclk, cs_n and sdi, and a clk-domain modulator that
// pulses conv_tick once per conversion cycle with its raw word on raw_sample.
`timescale 1ns/100ps

module acd_core (
  // System clock and synchronous active-low reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial link from the host.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Modulator side, clk domain.
  input wire logic conv_tick,
  input wire logic [23:0] raw_sample,
  // Conversion outputs, clk domain.
  output logic [15:0] result_word,
  output logic result_valid,
  output logic filter_clear,
  // Input selector controls, link domain.
  output logic [3:0] pos_input_select,
  output logic pos_open,
  output logic [3:0] neg_input_select,
  output logic neg_open,
  // Analog power and settings, link domain.
  output logic converter_power_enable,
  output logic dac_power_enable,
  output logic amp_two_power_enable,
  output logic amp_one_power_enable,
  output logic [9:0] dac_code,
  output logic [1:0] refbuf_level_select,
  output logic detect_comparator_enable,
  output logic [2:0] threshold_select
);

  // ==========================================================================
  // Link domain: frame shifter
  // ==========================================================================
  logic rst_s_n; // Reset as seen by the link clock.
  logic [5:0] cnt_q; // Bits taken in this frame.
  logic [23:0] sh_q; // Incoming shift register.
  logic [7:0] cmd_q; // Command byte of this frame.
  logic [23:0] tx_q; // Outgoing shift register.
  logic sdo_q; // Serial data out.
  logic oe_q; // Serial output enable.
  logic [23:0] rd_align; // Read word, left aligned for the shifter.

  acd_sync u_rst_sync (
    .clk(sclk),
    .d(nrst),
    .q(rst_s_n)
  );

  // Next shift value and the command seen by this edge.
  wire [23:0] sh_nx = {sh_q[22:0], sdi};
  wire cmd_done = (cnt_q == acd_pkg::CMD_LAST_CNT);
  wire [7:0] cmd_w = cmd_done ? sh_nx[7:0] : cmd_q;
  wire [4:0] reg_w = cmd_w[6:2];
  wire cmd_ok = cmd_w[acd_pkg::CMD_VALID_BIT];
  wire is_rd = cmd_w[acd_pkg::CMD_READ_BIT];
  wire s_bit = cmd_w[acd_pkg::CMD_START_BIT];
  wire is_sel = (reg_w == acd_pkg::REG_INPUT_SEL);

  // Data length of the addressed register; zero for unmapped ids.
  wire [5:0] len_w =
    (reg_w == acd_pkg::REG_ZERO_CORR || reg_w == acd_pkg::REG_SCALE_CORR) ? 6'h18 :
    (reg_w == acd_pkg::REG_RESULT || reg_w == acd_pkg::REG_DAC_CTRL ||
     reg_w == acd_pkg::REG_DAC2_CTRL) ? 6'h10 :
    (is_sel || reg_w == acd_pkg::REG_CONV_CTRL ||
     reg_w == acd_pkg::REG_REF_CTRL) ? 6'h08 : 6'h00;

  // A write commits only when its final data bit arrives; an aborted frame
  // never reaches that count, so nothing half-written is ever applied.
  // Aborted frames commit nothing.
  wire wr_fire = cmd_ok && !is_rd && (len_w != 6'h00) &&
                 (cnt_q == acd_pkg::CMD_LAST_CNT + len_w);
  wire wr_sel = wr_fire && is_sel;

  // The frame state is cleared by chip select itself, since the link clock
  // may stop the moment a frame ends.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 6'h00;
      sh_q <= 24'h000000;
      cmd_q <= 8'h00;
      tx_q <= 24'h000000;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
      sh_q <= sh_nx;
      cmd_q <= cmd_w;
      if (cmd_done && cmd_ok && is_rd) begin
        // First read bit is presented right after the command byte.
        sdo_q <= rd_align[23];
        tx_q <= {rd_align[22:0], 1'b0};
        oe_q <= 1'b1;
      end else begin
        sdo_q <= tx_q[23];
        tx_q <= {tx_q[22:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Link domain: host-written registers
  // ==========================================================================
  logic [7:0] sel_q; // Input selection codes.
  logic pwr_q; // Converter power enable.
  logic continuous_conv_bit_q; // Continuous conversion request.
  logic bip_q; // Bipolar coding.
  logic [23:0] zero_q; // Zero correction word.
  logic [23:0] scale_q; // Scale correction word.
  logic dae_q; // DAC and buffer power.
  logic op2_q; // Amplifier two power.
  logic op1_q; // Amplifier one power.
  logic [9:0] dac_q; // DAC code.
  logic [1:0] refv_q; // Reference buffer level.
  logic detect_comparator_enable_q; // Detector comparator power.
  logic [2:0] tsel_q; // Detector threshold.
  logic start_tgl_q; // Flips once per conversion start.
  logic cfg_tgl_q; // Flips once per committed write.
  logic pub_s; // Synchronised status toggle.
  logic pub_seen_q; // Last status toggle taken in.
  logic [16:0] st_q; // Status copy: run flag and result.
  logic [16:0] pub_q; // Published status word, clk domain.
  logic pub_tgl_q; // Flips when the published word changes, clk domain.

  // Bulk power bits act only inside a reference register write.
  wire bulk_on = wr_fire && (reg_w == acd_pkg::REG_REF_CTRL) && sh_nx[acd_pkg::REF_ON_BIT];
  wire bulk_off = wr_fire && (reg_w == acd_pkg::REG_REF_CTRL) && sh_nx[acd_pkg::REF_OFF_BIT];
  wire wr_cc = wr_fire && (reg_w == acd_pkg::REG_CONV_CTRL);
  wire wr_dac = wr_fire && (reg_w == acd_pkg::REG_DAC_CTRL);
  wire start_rd = cmd_done && cmd_ok && is_rd && is_sel && s_bit;
  wire start_any = start_rd || (wr_sel && s_bit) ||
                   (wr_cc && sh_nx[acd_pkg::CC_RUN_BIT]);

  wire pwr_d = bulk_on ? 1'b1 : bulk_off ? 1'b0 :
               wr_cc ? sh_nx[acd_pkg::CC_PWR_BIT] : pwr_q;
  wire dae_d = bulk_on ? 1'b1 : bulk_off ? 1'b0 :
               wr_dac ? sh_nx[acd_pkg::DAC_PWR_BIT] : dae_q;
  wire op2_d = bulk_on ? 1'b1 : bulk_off ? 1'b0 :
               wr_dac ? sh_nx[acd_pkg::AMP2_PWR_BIT] : op2_q;
  wire op1_d = bulk_on ? 1'b1 : bulk_off ? 1'b0 :
               wr_dac ? sh_nx[acd_pkg::AMP1_PWR_BIT] : op1_q;
  wire [7:0] sel_d = wr_sel ? sh_nx[7:0] : sel_q;
  wire pos_open_d = !pwr_d || (sel_d[7:4] > acd_pkg::LAST_INPUT_CODE);
  wire neg_open_d = !pwr_d || (sel_d[3:0] > acd_pkg::LAST_INPUT_CODE);

  // Status from the clk domain arrives as a toggle; the word stays stable
  // long after each toggle, so a copy on the toggle is safe.
  acd_sync u_pub_sync (
    .clk(sclk),
    .d(pub_tgl_q),
    .q(pub_s)
  );

  // Register file updates on the link clock.
  always_ff @(posedge sclk) begin
    if (!rst_s_n) begin
      sel_q <= acd_pkg::INPUT_SEL_RST;
      pwr_q <= 1'b0;
      continuous_conv_bit_q <= 1'b0;
      bip_q <= 1'b0;
      zero_q <= acd_pkg::ZERO_CORR_RST;
      scale_q <= acd_pkg::SCALE_CORR_RST;
      dae_q <= 1'b0;
      op2_q <= 1'b0;
      op1_q <= 1'b0;
      dac_q <= acd_pkg::DAC_CODE_RST;
      refv_q <= acd_pkg::REFBUF_RST;
      detect_comparator_enable_q <= 1'b0;
      tsel_q <= acd_pkg::THRESH_RST;
      start_tgl_q <= 1'b0;
      cfg_tgl_q <= 1'b0;
      pub_seen_q <= 1'b0;
      st_q <= 17'h00000;
      pos_input_select <= 4'h0;
      neg_input_select <= 4'h0;
      pos_open <= 1'b1;
      neg_open <= 1'b1;
    end else begin
      sel_q <= sel_d;
      pwr_q <= pwr_d;
      dae_q <= dae_d;
      op2_q <= op2_d;
      op1_q <= op1_d;
      pos_input_select <= sel_d[7:4];
      neg_input_select <= sel_d[3:0];
      pos_open <= pos_open_d;
      neg_open <= neg_open_d;
      if (wr_cc) begin
        continuous_conv_bit_q <= sh_nx[acd_pkg::CC_CONTINUOUS_CONV_BIT_BIT];
        bip_q <= sh_nx[acd_pkg::CC_BIP_BIT];
      end
      if (wr_fire && reg_w == acd_pkg::REG_ZERO_CORR) begin
        zero_q <= sh_nx;
      end
      if (wr_fire && reg_w == acd_pkg::REG_SCALE_CORR) begin
        scale_q <= sh_nx;
      end
      // DAC code lands on last bit.
      if (wr_dac) begin
        dac_q <= sh_nx[9:0];
      end
      if (wr_fire && reg_w == acd_pkg::REG_REF_CTRL) begin
        refv_q <= sh_nx[7:6];
        detect_comparator_enable_q <= sh_nx[acd_pkg::REF_DETECT_COMPARATOR_ENABLE_BIT];
        tsel_q <= sh_nx[2:0];
      end
      if (start_any) begin
        start_tgl_q <= !start_tgl_q;
      end
      if (wr_fire) begin
        cfg_tgl_q <= !cfg_tgl_q;
      end
      pub_seen_q <= pub_s;
      if (pub_s != pub_seen_q) begin
        st_q <= pub_q;
      end
    end
  end

  // Read data, left aligned in the 24-bit shifter; the run flag shows the
  // clk-domain state, which may lag a just-issued start by a few edges.
  wire [23:0] rd_word =
    (reg_w == acd_pkg::REG_INPUT_SEL) ? {16'h0000, sel_q} :
    (reg_w == acd_pkg::REG_CONV_CTRL) ? {16'h0000, pwr_q, continuous_conv_bit_q, bip_q, st_q[16], 4'h0} :
    (reg_w == acd_pkg::REG_RESULT) ? {8'h00, st_q[15:0]} :
    (reg_w == acd_pkg::REG_ZERO_CORR) ? zero_q :
    (reg_w == acd_pkg::REG_SCALE_CORR) ? scale_q :
    (reg_w == acd_pkg::REG_DAC_CTRL) ? {8'h00, dae_q, op2_q, op1_q, 3'h0, dac_q} :
    (reg_w == acd_pkg::REG_DAC2_CTRL) ? {10'h000, op1_q, 13'h0000} :
    (reg_w == acd_pkg::REG_REF_CTRL) ? {16'h0000, refv_q, 2'h0, detect_comparator_enable_q, tsel_q} :
    24'h000000;
  assign rd_align = (len_w == 6'h08) ? {rd_word[7:0], 16'h0000} :
                         (len_w == 6'h10) ? {rd_word[15:0], 8'h00} : rd_word;

  // Link-domain outputs straight from their registers.
  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign converter_power_enable = pwr_q;
  assign dac_power_enable = dae_q;
  assign amp_two_power_enable = op2_q;
  assign amp_one_power_enable = op1_q;
  assign dac_code = dac_q;
  assign refbuf_level_select = refv_q;
  assign detect_comparator_enable = detect_comparator_enable_q;
  assign threshold_select = tsel_q;

  // ==========================================================================
  // Clk domain: settings copy and start detection
  // ==========================================================================
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_RUN} acd_state_type;

  acd_state_type state_q; // Conversion sequencer state.
  logic cfg_s; // Synchronised write toggle.
  logic cfg_seen_q; // Last write toggle taken in.
  logic start_s; // Synchronised start toggle.
  logic start_seen_q; // Last start toggle taken in.
  logic c_pwr_q; // Power enable copy.
  logic c_continuous_conv_bit_q; // Continuous request copy.
  logic c_bip_q; // Bipolar copy.
  logic [23:0] c_zero_q; // Zero correction copy.
  logic [23:0] c_scale_q; // Scale correction copy.
  logic [2:0] fill_q; // Conversion cycles since start.
  logic run_q; // Converter run flag.
  logic [15:0] res_q; // Conversion result.
  logic valid_q; // Result strobe.
  logic clr_q; // Filter clear strobe.

  acd_sync u_cfg_sync (
    .clk(clk),
    .d(cfg_tgl_q),
    .q(cfg_s)
  );

  acd_sync u_start_sync (
    .clk(clk),
    .d(start_tgl_q),
    .q(start_s)
  );

  // The link word is stable for many link edges after its toggle flips.
  wire cfg_new = (cfg_s != cfg_seen_q);
  wire start_evt = (start_s != start_seen_q);
  wire pwr_now = cfg_new ? pwr_q : c_pwr_q;
  wire continuous_conv_bit_now = cfg_new ? continuous_conv_bit_q : c_continuous_conv_bit_q;

  // ==========================================================================
  // Clk domain: correction arithmetic
  // ==========================================================================
  // Raw word is signed in bipolar mode and unsigned otherwise.
  wire signed [25:0] raw_ext = c_bip_q ? {{2{raw_sample[23]}}, raw_sample}
                                       : {2'b00, raw_sample};
  wire signed [25:0] diff = raw_ext - {{2{c_zero_q[23]}}, c_zero_q};
  wire signed [51:0] prod = diff * $signed({2'b00, c_scale_q});
  wire signed [28:0] scaled = prod[51:23];
  // Saturate to the 24-bit range of the selected coding, keep the top 16.
  wire [23:0] sat_bip = (scaled > 29'sh07FFFFF) ? 24'h7FFFFF :
                        (scaled < -29'sh0800000) ? 24'h800000 : scaled[23:0];
  wire [23:0] sat_uni = (scaled < 29'sh0000000) ? 24'h000000 :
                        (scaled > 29'sh0FFFFFF) ? 24'hFFFFFF : scaled[23:0];
  wire [15:0] res_d = c_bip_q ? sat_bip[23:8] : sat_uni[23:8];

  // ==========================================================================
  // Clk domain: sequencer
  // ==========================================================================
  // Fourth cycle gives first result.
  wire fill_done = (state_q == ST_FILL) && conv_tick &&
                   (fill_q == acd_pkg::FILL_CYCLES - 3'h1);
  wire run_done = (state_q == ST_RUN) && conv_tick;
  wire take = fill_done || run_done;

  // Start always wins over a completion in the same cycle.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cfg_seen_q <= 1'b0;
      start_seen_q <= 1'b0;
      c_pwr_q <= 1'b0;
      c_continuous_conv_bit_q <= 1'b0;
      c_bip_q <= 1'b0;
      c_zero_q <= acd_pkg::ZERO_CORR_RST;
      c_scale_q <= acd_pkg::SCALE_CORR_RST;
      fill_q <= 3'h0;
      run_q <= 1'b0;
      res_q <= acd_pkg::RESULT_RST;
      valid_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      cfg_seen_q <= cfg_s;
      start_seen_q <= start_s;
      if (cfg_new) begin
        c_pwr_q <= pwr_q;
        c_continuous_conv_bit_q <= continuous_conv_bit_q;
        c_bip_q <= bip_q;
        c_zero_q <= zero_q;
        c_scale_q <= scale_q;
      end
      valid_q <= take && pwr_now;
      clr_q <= start_evt && pwr_now;
      if (take && pwr_now) begin
        res_q <= res_d;
      end
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_IDLE;
        end
        ST_FILL: begin
          if (conv_tick) begin
            fill_q <= fill_q + 3'h1;
          end
          if (fill_done) begin
            state_q <= continuous_conv_bit_now ? ST_RUN : ST_IDLE;
          end
        end
        ST_RUN: begin
          if (!continuous_conv_bit_now) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (fill_done) begin
        run_q <= 1'b0;
      end
      if (!pwr_now) begin
        state_q <= ST_IDLE;
        run_q <= 1'b0;
      end
      if (start_evt && pwr_now) begin
        state_q <= ST_FILL;
        fill_q <= 3'h0;
        run_q <= 1'b1;
      end
    end
  end

  // Status word published to the link side whenever it changes.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pub_q <= 17'h00000;
      pub_tgl_q <= 1'b0;
    end else if (pub_q != {run_q, res_q}) begin
      pub_q <= {run_q, res_q};
      pub_tgl_q <= !pub_tgl_q;
    end
  end

  assign result_word = res_q;
  assign result_valid = valid_q;
  assign filter_clear = clr_q;

endmodule // acd_core

// ### inc/acd_pkg.sv
// Shared constants for the converter control block: register ids, field
// positions, reset values and the command byte bit count.
// Assumes a single serial register port and a clk-domain conversion core.
package acd_pkg;

  // ==========================================================================
  // Command byte layout
  // ==========================================================================
  // Bit 7 marks a valid command, 6:2 select the register, 1 is the start bit.
  localparam int CMD_VALID_BIT = 7;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_READ_BIT = 0;
  localparam logic [5:0] CMD_LAST_CNT = 6'h07;

  // ==========================================================================
  // Register identifiers
  // ==========================================================================
  localparam logic [4:0] REG_CONV_CTRL = 5'h01;
  localparam logic [4:0] REG_INPUT_SEL = 5'h07;
  localparam logic [4:0] REG_RESULT = 5'h08;
  localparam logic [4:0] REG_ZERO_CORR = 5'h09;
  localparam logic [4:0] REG_SCALE_CORR = 5'h0A;
  localparam logic [4:0] REG_DAC_CTRL = 5'h0B;
  localparam logic [4:0] REG_DAC2_CTRL = 5'h0C;
  localparam logic [4:0] REG_REF_CTRL = 5'h0D;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  // Converter control register.
  localparam int CC_PWR_BIT = 7;
  localparam int CC_CONTINUOUS_CONV_BIT_BIT = 6;
  localparam int CC_BIP_BIT = 5;
  localparam int CC_RUN_BIT = 4;
  // DAC and amplifier control register.
  localparam int DAC_PWR_BIT = 15;
  localparam int AMP2_PWR_BIT = 14;
  localparam int AMP1_PWR_BIT = 13;
  // Reference and detector control register.
  localparam int REF_OFF_BIT = 5;
  localparam int REF_ON_BIT = 4;
  localparam int REF_DETECT_COMPARATOR_ENABLE_BIT = 3;

  // ==========================================================================
  // Reset values and codes
  // ==========================================================================
  localparam logic [7:0] INPUT_SEL_RST = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [23:0] ZERO_CORR_RST = 24'h000000;
  localparam logic [23:0] SCALE_CORR_RST = 24'h800000;
  localparam logic [9:0] DAC_CODE_RST = 10'h000;
  localparam logic [1:0] REFBUF_RST = 2'h0;
  localparam logic [2:0] THRESH_RST = 3'h0;
  localparam logic [3:0] LAST_INPUT_CODE = 4'h9;
  localparam int SCALE_FRAC_BITS = 23;
  // Conversion cycles before the first valid result after a start.
  localparam logic [2:0] FILL_CYCLES = 3'h4;

endpackage

// ### hw/acd_sync.sv
// Two-flop synchroniser for one level or toggle.
// Assumes the input changes no faster than the destination clock can see.
`timescale 1ns/100ps

module acd_sync (
  // Destination clock.
  input wire logic clk,
  // Signal from the other domain.
  input wire logic d,
  // Synchronised copy.
  output logic q
);

  // First stage; only the second stage reads it.
  logic meta_q;

  // The pair runs free; reset is not needed for a toggle path.
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule // acd_sync

// ### verif/acd_core_sva.sv
// Port checker for acd_core, bound into every instance.
// Assumes the host clocks sclk only inside frames, command byte first.
`timescale 1ns/100ps
module acd_core_chk (
  // Clocks, reset, link and modulator inputs.
  input wire logic clk, nrst, sclk, cs_n, sdi, conv_tick,
  // Conversion outputs.
  input wire logic [15:0] result_word,
  input wire logic result_valid, filter_clear,
  // Selector, power and settings outputs.
  input wire logic [3:0] pos_input_select, neg_input_select,
  input wire logic pos_open, neg_open, converter_power_enable, dac_power_enable,
  input wire logic amp_two_power_enable, amp_one_power_enable,
  input wire logic [9:0] dac_code,
  input wire logic [1:0] refbuf_level_select
);
  // Frame bit count; chip select high restarts it.
  logic [4:0] bc_q;
  logic [22:0] sh_q;
  logic [2:0] tk_q;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) bc_q <= 5'h00;
    else bc_q <= bc_q + {4'h0, bc_q != 5'h1F};
  end
  always_ff @(posedge sclk) sh_q <= {sh_q[21:0], sdi};
  // Ticks since the last filter clear, saturating so continuous runs stay legal.
  always_ff @(posedge clk) begin
    if (!nrst || filter_clear) tk_q <= 3'h0;
    else if (conv_tick && tk_q != 3'h7) tk_q <= tk_q + 3'h1;
  end
  wire [7:0] cmd8 = sh_q[14:7];
  wire [7:0] d8 = {sh_q[6:0], sdi};
  wire [1:0] lv8 = d8[7:6];
  wire [12:0] dac_w = {sh_q[14:12], sh_q[8:0], sdi};
  wire w16 = bc_q == 5'h17 && sh_q[22:15] == 8'hAC;
  wire sel_w = bc_q == 5'h0F && cmd8[7:2] == 6'h27 && !cmd8[0];
  wire ref_w = bc_q == 5'h0F && cmd8 == 8'hB4;
  wire [3:0] en4 = {converter_power_enable, dac_power_enable, amp_two_power_enable,
    amp_one_power_enable};
  a_open_off: assert property (@(posedge sclk) disable iff (!nrst)
    !converter_power_enable && !$past(converter_power_enable) |-> pos_open && neg_open)
    else $error("input path driven while powered down");
  a_pos_decode: assert property (@(posedge sclk) disable iff (!nrst)
    converter_power_enable && $past(converter_power_enable) && $stable(pos_input_select)
    |-> pos_open == (pos_input_select > 4'h9)) else $error("positive path decode wrong");
  a_neg_decode: assert property (@(posedge sclk) disable iff (!nrst)
    converter_power_enable && $past(converter_power_enable) && $stable(neg_input_select)
    |-> neg_open == (neg_input_select > 4'h9)) else $error("negative path decode wrong");
  a_sel_commit: assert property (@(posedge sclk) disable iff (!nrst) sel_w
    |=> {pos_input_select, neg_input_select} == $past(d8)) else $error("selection not taken");
  a_bulk_on: assert property (@(posedge sclk) disable iff (!nrst) ref_w && d8[4]
    |=> en4 == 4'hF) else $error("bulk power on missed an enable");
  a_bulk_off: assert property (@(posedge sclk) disable iff (!nrst)
    ref_w && d8[5] && !d8[4] |=> en4 == 4'h0) else $error("bulk power off missed");
  a_ref_level: assert property (@(posedge sclk) disable iff (!nrst) ref_w
    |=> refbuf_level_select == $past(lv8)) else $error("reference level not taken");
  a_dac_commit: assert property (@(posedge sclk) disable iff (!nrst) w16
    |=> {en4[2:0], dac_code} == $past(dac_w)) else $error("dac word not taken");
  a_fill_four: assert property (@(posedge clk) disable iff (!nrst)
    result_valid |-> tk_q >= 3'h4 && $past(conv_tick)) else $error("result before fill");
  a_result_hold: assert property (@(posedge clk) disable iff (!nrst)
    !$stable(result_word) |-> ##[0:1] result_valid) else $error("result moved unannounced");
endmodule // acd_core_chk
bind acd_core acd_core_chk acd_core_chk_inst (.clk, .nrst, .sclk, .cs_n, .sdi, .conv_tick,
  .result_word, .result_valid, .filter_clear, .pos_input_select, .neg_input_select,
  .pos_open, .neg_open, .converter_power_enable, .dac_power_enable,
  .amp_two_power_enable, .amp_one_power_enable, .dac_code, .refbuf_level_select);

// ### verif/acd_host.sv
// Host model for the serial register link.
// Assumes the bench calls its tasks one at a time; sclk idles low.
`timescale 1ns/100ps
module acd_host (
  // Lines toward the device.
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  // Answer from the device.
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Pulses with chip select high, so the link side sees reset edges.
  task idle(input int n);
    repeat (n) begin
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
  endtask
  task xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n, input int stop,
    output logic [23:0] rd);
    rd = 24'h0;
    cs_n = 1'b0;
    for (int e = 0; e < stop; e++) begin
      // Bits past the data length toggle so stale levels never look valid.
      sdi = (e < 8) ? cmd[7 - e] : (e < 8 + n) ? wd[n + 7 - e] : ~sdi;
      // Data bit k stands after the edge that took frame bit 7+k.
      if (e >= 8 && e < 8 + n) rd = {rd[22:0], sdo};
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    #12;
  endtask
endmodule // acd_host

// ### verif/tb.sv
// Self-checking bench for acd_core.
// Assumes the checker and host model files are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t got %0h expected %0h", $time, (a), (e)); end end
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic conv_tick = 1'b0;
  logic [23:0] raw_sample = 24'h0;
  logic [23:0] rd;
  int err_total = 0, cmp_count = 0, cyc = 0, vcnt = 0, fcnt = 0, v0, f0;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe, result_valid, filter_clear, pos_open, neg_open;
  wire logic converter_power_enable, dac_power_enable, amp_two_power_enable;
  wire logic amp_one_power_enable;
  wire logic [15:0] result_word;
  wire logic [3:0] pos_input_select, neg_input_select;
  wire logic [9:0] dac_code;
  wire logic [1:0] refbuf_level_select;
  wire logic detect_comparator_enable;
  wire logic [2:0] threshold_select;
  wire logic [3:0] det4 = {detect_comparator_enable, threshold_select};
  wire logic [3:0] en4 = {converter_power_enable, dac_power_enable, amp_two_power_enable,
    amp_one_power_enable};
  acd_core acd_core_inst (.clk, .nrst, .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .conv_tick,
    .raw_sample, .result_word, .result_valid, .filter_clear, .pos_input_select, .pos_open,
    .neg_input_select, .neg_open, .converter_power_enable, .dac_power_enable,
    .amp_two_power_enable, .amp_one_power_enable, .dac_code, .refbuf_level_select,
    .detect_comparator_enable, .threshold_select);
  acd_host acd_host_inst (.sclk, .cs_n, .sdi, .sdo);
  always #2.5 clk = ~clk;
  // Pulse counters and the hang limit.
  always @(posedge clk) begin
    vcnt <= vcnt + (result_valid === 1'b1);
    fcnt <= fcnt + (filter_clear === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] cmd, input logic [23:0] d, input int n);
    acd_host_inst.xfer(cmd, d, n, n + 9, rd);
  endtask
  task rdchk(input logic [7:0] cmd, input int n, input logic [23:0] e);
    acd_host_inst.xfer(cmd, 24'h0, n, n + 9, rd);
    `CHK(rd, e)
  endtask
  // One modulator tick, then time for the registered answer to land.
  task tick(input logic [23:0] v);
    @(posedge clk) #1 conv_tick = 1'b1;
    raw_sample = v;
    @(posedge clk) #1 conv_tick = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    `CHK({sdo_oe, en4, pos_open, neg_open}, 7'h03)
    `CHK(refbuf_level_select, 2'h0)
    rdchk(8'hA9, 24, 24'h800000);
    rdchk(8'hA1, 16, 24'h0);
    rdchk(8'hFD, 8, 24'h0);
    $display("reset test done");
  endtask
  task t_bulk;
    wr(8'hB4, 24'hB0, 8);
    `CHK({en4, refbuf_level_select}, 6'h3E)
    wr(8'hB4, 24'h20, 8);
    `CHK(en4, 4'h0)
    for (int c = 0; c < 4; c++) begin
      wr(8'hB4, {16'h0, c[1:0], 6'h1D}, 8);
      `CHK({en4, refbuf_level_select, det4}, {4'hF, c[1:0], 4'hD})
    end
    rdchk(8'hB5, 8, 24'hCD);
    $display("bulk power test done");
  endtask
  task t_dac;
    wr(8'hAC, 24'h63FF, 16);
    `CHK({en4[2:0], dac_code}, 13'h0FFF)
    acd_host_inst.xfer(8'hAC, 24'h8155, 16, 23, rd);
    `CHK({en4[2:0], dac_code}, 13'h0FFF)
    rdchk(8'hB1, 16, 24'h2000);
    $display("dac test done");
  endtask
  task t_mux;
    f0 = fcnt;
    wr(8'h9C, 24'h9A, 8);
    `CHK({pos_input_select, pos_open, neg_input_select, neg_open}, 10'h255)
    wr(8'h9C, 24'hA5, 8);
    `CHK({pos_input_select, pos_open, neg_input_select, neg_open}, 10'h2AA)
    wr(8'h9C, 24'hC9, 8);
    `CHK({pos_input_select, pos_open, neg_input_select, neg_open}, 10'h332)
    `CHK(fcnt - f0, 0)
    wr(8'hB4, 24'h20, 8);
    `CHK({pos_open, neg_open}, 2'h3)
    wr(8'hB4, 24'h10, 8);
    $display("selector test done");
  endtask
  task t_conv;
    wr(8'hA4, 24'h000100, 24);
    wr(8'hA8, 24'h400000, 24);
    wr(8'h84, 24'h80, 8);
    f0 = fcnt;
    v0 = vcnt;
    acd_host_inst.xfer(8'h9F, 24'h0, 0, 10, rd);
    repeat (10) @(posedge clk);
    `CHK(fcnt - f0, 1)
    rdchk(8'h85, 8, 24'h90);
    repeat (3) tick(24'h123400);
    `CHK(vcnt - v0, 0)
    tick(24'h123400);
    `CHK({vcnt - v0, result_word}, {32'd1, 16'h0919})
    tick(24'h200100);
    `CHK(vcnt - v0, 1)
    rdchk(8'hA1, 16, 24'h0919);
    rdchk(8'h85, 8, 24'h80);
    $display("single conversion test done");
  endtask
  task t_continuous_conv_bit;
    wr(8'h84, 24'hC0, 8);
    acd_host_inst.xfer(8'h9F, 24'h0, 8, 17, rd);
    `CHK(rd, 24'hC9)
    repeat (10) @(posedge clk);
    v0 = vcnt;
    repeat (5) tick(24'h200100);
    `CHK({vcnt - v0, result_word}, {32'd2, 16'h1000})
    wr(8'hB4, 24'h20, 8);
    repeat (10) @(posedge clk);
    v0 = vcnt;
    f0 = fcnt;
    tick(24'h200100);
    acd_host_inst.xfer(8'h9F, 24'h0, 0, 8, rd);
    repeat (10) @(posedge clk);
    `CHK({vcnt - v0, fcnt - f0}, 64'h0)
    $display("continuous test done");
  endtask
  initial begin
    fork
      acd_host_inst.idle(4);
      repeat (3) @(posedge clk);
    join
    @(posedge clk) #1 nrst = 1'b1;
    acd_host_inst.idle(3);
    t_reset();
    t_bulk();
    t_dac();
    t_mux();
    t_conv();
    t_continuous_conv_bit();
    close_out();
  end
endmodule // tb
